// ===== rtl/rtm_pkg.sv
// Constants, encodings and carrier types of the range type map block
`default_nettype none
package rtm_pkg;
    // Memory type encodings
    localparam logic [7:0] MT_UNCACHED = 8'h00;
    localparam logic [7:0] MT_COMBINING = 8'h01;
    localparam logic [7:0] MT_THROUGH = 8'h04;
    localparam logic [7:0] MT_PROTECTED = 8'h05;
    localparam logic [7:0] MT_BACK = 8'h06;
    // Capability value: eight variable ranges, fixed ranges, write combining
    localparam logic [63:0] CAP_VALUE = 64'h0000_0000_0000_0508;
    localparam int unsigned CAP_FIX_BIT = 8;
    localparam int unsigned CAP_COMB_BIT = 10;
    localparam int unsigned NUM_VAR = 8;
    localparam int unsigned NUM_FIX = 11;
    localparam int unsigned MAX_RANGES = 96;
    // Model register numbers of the map
    localparam logic [15:0] ADDR_CAP = 16'h0000;
    localparam logic [15:0] ADDR_DEF = 16'h0001;
    localparam logic [15:0] ADDR_FIX0 = 16'h0010;
    localparam logic [15:0] ADDR_VAR0 = 16'h0020;
    // Default type register fields
    localparam int unsigned DEF_FE_BIT = 10;
    localparam int unsigned DEF_E_BIT = 11;
    localparam logic [63:0] DEF_RSVD = 64'hFFFF_FFFF_FFFF_F300;
    localparam logic [63:0] DEF_RESET = 64'h0000_0000_0000_0000;
    // Variable pair fields
    localparam int unsigned VAR_V_BIT = 11;
    localparam logic [63:0] VBASE_LOW_RSVD = 64'h0000_0000_0000_0F00;
    localparam logic [63:0] VMASK_LOW_RSVD = 64'h0000_0000_0000_07FF;
    // Control register flag positions
    localparam int unsigned PRI_PROT_BIT = 0;
    localparam int unsigned PRI_PAGING_BIT = 31;
    localparam int unsigned EXT_BIGPAGE_BIT = 4;
    localparam int unsigned EXT_WIDEADDR_BIT = 5;
    localparam int unsigned EXT_GLOBAL_BIT = 7;
    // Identity query feature bit
    localparam int unsigned FEAT_RANGE_BIT = 12;
    localparam logic [31:0] FEAT_VALUE = 32'h0000_1000;

    typedef enum logic [1:0] {RTM_CR_PRIMARY, RTM_CR_BASE, RTM_CR_EXT, RTM_CR_NONE} rtm_cr_sel_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [63:0] data;
    } rtm_msr_req_t;

    typedef struct packed {
        logic valid;
        rtm_cr_sel_t sel;
        logic [31:0] data;
    } rtm_cr_wr_t;

    typedef struct packed {
        logic all;
        logic nonpersist;
        logic page;
        logic [31:0] page_addr;
    } rtm_purge_t;
endpackage : rtm_pkg
`default_nettype wire

// ===== rtl/rtm_core.sv
// Range type map registers and translation cache purge control
`timescale 1ns/1ns
`default_nettype none

module rtm_core import rtm_pkg::*; #(
    parameter int unsigned PHYS_W = 36
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire rtm_msr_req_t msr_req_in,
    input wire rtm_cr_wr_t cr_wr_in,
    input wire logic page_purge_in,
    input wire logic [31:0] page_addr_in,
    input wire logic purge_pin_n_in,
    input wire logic [PHYS_W-1:0] lookup_addr_in,
    output logic msr_ack_out,
    output logic msr_fault_out,
    output logic [63:0] msr_rdata_out,
    output rtm_purge_t purge_out,
    output logic [31:0] feature_bits_out,
    output logic [7:0] mem_type_out
);
    // Address bits above the physical width are reserved in base and mask
    localparam logic [63:0] HIGH_RSVD = ~((64'h1 << PHYS_W) - 64'h1);

    // Legal memory type check
    function automatic logic type_ok(input logic [7:0] t);
        type_ok = t inside {MT_UNCACHED, MT_COMBINING, MT_THROUGH, MT_PROTECTED, MT_BACK};
    endfunction : type_ok

    // Every byte of a fixed register is a type field
    function automatic logic bytes_ok(input logic [63:0] v);
        logic ok;
        ok = 1'b1;
        for (int b = 0; b < 8; b++) begin
            ok = ok & type_ok(v[8*b +: 8]);
        end
        bytes_ok = ok;
    endfunction : bytes_ok

    logic [63:0] def_ff;
    logic [63:0] fix_ff [NUM_FIX];
    logic [63:0] var_ff [2*NUM_VAR];
    logic pin_ff;
    logic prot_ff;
    logic paging_ff;
    logic [2:0] ext_ff;

    // Address decode of the model register space
    wire logic [15:0] fix_off = msr_req_in.addr - ADDR_FIX0;
    wire logic [15:0] var_off = msr_req_in.addr - ADDR_VAR0;
    wire logic is_cap = msr_req_in.addr == ADDR_CAP;
    wire logic is_def = msr_req_in.addr == ADDR_DEF;
    wire logic is_fix = fix_off < 16'(NUM_FIX);
    wire logic is_var = var_off < 16'(2 * NUM_VAR);
    wire logic [3:0] fix_idx = fix_off[3:0];
    wire logic [3:0] var_idx = var_off[3:0];
    wire logic mapped = is_cap | is_def | is_fix | is_var;

    // Field checks; reserved bits or types refuse the write
    wire logic def_bad = |(msr_req_in.data & DEF_RSVD) | ~type_ok(msr_req_in.data[7:0]);
    wire logic fix_bad = ~bytes_ok(msr_req_in.data);
    wire logic vbase_bad = |(msr_req_in.data & (VBASE_LOW_RSVD | HIGH_RSVD)) | ~type_ok(msr_req_in.data[7:0]);
    wire logic vmask_bad = |(msr_req_in.data & (VMASK_LOW_RSVD | HIGH_RSVD));
    wire logic var_bad = var_idx[0] ? vmask_bad : vbase_bad;
    wire logic wr_bad = ~mapped | is_cap | (is_def & def_bad) | (is_fix & fix_bad) | (is_var & var_bad);
    wire logic wr_ok = msr_req_in.wr & ~wr_bad;

    // Read data selection; capability is a constant
    wire logic [63:0] rd_data = is_cap ? CAP_VALUE :
                                is_def ? def_ff :
                                is_fix ? fix_ff[fix_idx] :
                                is_var ? var_ff[var_idx] : 64'h0000_0000_0000_0000;

    // Purge causes
    wire logic pin_edge = pin_ff ^ purge_pin_n_in;
    wire logic pri_wr = cr_wr_in.valid & (cr_wr_in.sel == RTM_CR_PRIMARY);
    wire logic ext_wr = cr_wr_in.valid & (cr_wr_in.sel == RTM_CR_EXT);
    wire logic base_wr = cr_wr_in.valid & (cr_wr_in.sel == RTM_CR_BASE);
    // Only a change of a watched flag counts; rewriting the same value costs nothing
    wire logic pri_chg = pri_wr &
        ((cr_wr_in.data[PRI_PROT_BIT] ^ prot_ff) | (cr_wr_in.data[PRI_PAGING_BIT] ^ paging_ff));
    wire logic [2:0] ext_new = {cr_wr_in.data[EXT_WIDEADDR_BIT], cr_wr_in.data[EXT_GLOBAL_BIT],
        cr_wr_in.data[EXT_BIGPAGE_BIT]};
    wire logic ext_chg = ext_wr & (ext_new != ext_ff);
    wire logic nxt_all = pin_edge | wr_ok | pri_chg | ext_chg;
    // A full purge already covers the partial ones, so those are dropped under it
    wire logic nxt_nonpersist = base_wr & ~nxt_all;
    wire logic nxt_page = page_purge_in & ~nxt_all;

    // Variable range match; lowest pair wins an overlap
    logic [NUM_VAR-1:0] var_hit;
    generate
        for (genvar i = 0; i < NUM_VAR; i++) begin : g_var
            wire logic [63:0] vb = var_ff[2*i];
            wire logic [63:0] vm = var_ff[2*i+1];
            assign var_hit[i] = vm[VAR_V_BIT] &&
                ((lookup_addr_in[PHYS_W-1:12] & vm[PHYS_W-1:12]) == (vb[PHYS_W-1:12] & vm[PHYS_W-1:12]));
        end
    endgenerate

    // Fixed range field select below 1 MiB
    wire logic in_fixed = lookup_addr_in[PHYS_W-1:20] == '0;
    wire logic [3:0] fsel = ~lookup_addr_in[19] ? 4'h0 :
                            ~lookup_addr_in[18] ? {3'h0, lookup_addr_in[17]} + 4'h1 :
                            {1'h0, lookup_addr_in[17:15]} + 4'h3;
    wire logic [2:0] fbyte = ~lookup_addr_in[19] ? lookup_addr_in[18:16] :
                             ~lookup_addr_in[18] ? lookup_addr_in[16:14] : lookup_addr_in[14:12];
    wire logic [63:0] fix_word = fix_ff[fsel];
    wire logic [7:0] fix_type = fix_word[8*fbyte +: 8];

    // Memory type of the looked-up address
    logic [7:0] var_type;
    logic var_any;
    always_comb begin
        var_type = MT_UNCACHED;
        var_any = 1'b0;
        // Walk from the top so the lowest matching pair is left standing
        for (int i = NUM_VAR - 1; i >= 0; i--) begin
            if (var_hit[i]) begin
                var_type = var_ff[2*i][7:0];
                var_any = 1'b1;
            end
        end
    end

    wire logic [7:0] nxt_type = ~def_ff[DEF_E_BIT] ? MT_UNCACHED :
                                (def_ff[DEF_FE_BIT] & in_fixed) ? fix_type :
                                var_any ? var_type : def_ff[7:0];

    // Range registers; each processor holds its own copy, nothing syncs them
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            def_ff <= DEF_RESET;
            for (int i = 0; i < NUM_FIX; i++) begin
                fix_ff[i] <= 64'h0000_0000_0000_0000;
            end
            for (int i = 0; i < 2 * NUM_VAR; i++) begin
                var_ff[i] <= 64'h0000_0000_0000_0000;
            end
        end else if (wr_ok) begin
            if (is_def) begin
                def_ff <= msr_req_in.data;
            end
            if (is_fix) begin
                fix_ff[fix_idx] <= msr_req_in.data;
            end
            if (is_var) begin
                var_ff[var_idx] <= msr_req_in.data;
            end
        end
    end

    // Model register answer, one cycle after the request
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            msr_ack_out <= 1'b0;
            msr_fault_out <= 1'b0;
            msr_rdata_out <= 64'h0000_0000_0000_0000;
        end else begin
            msr_ack_out <= msr_req_in.wr | msr_req_in.rd;
            // Unmapped reads fault too, so software never trusts a phantom zero
            msr_fault_out <= (msr_req_in.wr & wr_bad) | (msr_req_in.rd & ~mapped);
            msr_rdata_out <= msr_req_in.rd ? rd_data : 64'h0000_0000_0000_0000;
        end
    end

    // Shadow of the flags whose change forces a full purge
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_ff <= 1'b1; // Pin taken as released at reset
            prot_ff <= 1'b0;
            paging_ff <= 1'b0;
            ext_ff <= 3'h0;
        end else begin
            pin_ff <= purge_pin_n_in;
            if (pri_wr) begin
                prot_ff <= cr_wr_in.data[PRI_PROT_BIT];
                paging_ff <= cr_wr_in.data[PRI_PAGING_BIT];
            end
            if (ext_wr) begin
                ext_ff <= ext_new;
            end
        end
    end

    // Purge commands leave one cycle after their cause, ahead of any later lookup
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            purge_out <= '0;
            feature_bits_out <= FEAT_VALUE;
            mem_type_out <= MT_UNCACHED;
        end else begin
            purge_out.all <= nxt_all;
            purge_out.nonpersist <= nxt_nonpersist;
            purge_out.page <= nxt_page;
            purge_out.page_addr <= nxt_page ? page_addr_in : 32'h0000_0000;
            feature_bits_out <= FEAT_VALUE;
            mem_type_out <= nxt_type;
        end
    end

    // Checks share the core clock and stay quiet while reset is held
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    // A primary write is a flip when the new flag differs from the one last written
    sequence s_pri_wr;
        cr_wr_in.valid && cr_wr_in.sel == RTM_CR_PRIMARY;
    endsequence
    sequence s_paging_flip;
        s_pri_wr ##0 (cr_wr_in.data[PRI_PAGING_BIT] != paging_ff);
    endsequence
    sequence s_prot_flip;
        s_pri_wr ##0 (cr_wr_in.data[PRI_PROT_BIT] != prot_ff);
    endsequence
    // An extension write is a flip when any watched flag differs from its shadow
    sequence s_ext_flip;
        (cr_wr_in.valid && cr_wr_in.sel == RTM_CR_EXT) ##0 (ext_new != ext_ff);
    endsequence
    // Register requests; an idle cycle must leave no answer behind
    sequence s_msr_req;
        msr_req_in.wr || msr_req_in.rd;
    endsequence
    sequence s_msr_idle;
        !msr_req_in.wr && !msr_req_in.rd;
    endsequence
    // No purge cause at all in this cycle
    sequence s_no_cause;
        !cr_wr_in.valid && !msr_req_in.wr && !page_purge_in && (purge_pin_n_in == pin_ff);
    endsequence
    // Which map group decides the type of the looked-up address
    sequence s_fixed_on;
        def_ff[DEF_E_BIT] && def_ff[DEF_FE_BIT] && in_fixed;
    endsequence
    sequence s_var_on;
        def_ff[DEF_E_BIT] && !(def_ff[DEF_FE_BIT] && in_fixed) && var_any;
    endsequence

    cap_read_a: assert property (msr_req_in.rd && is_cap |=> msr_rdata_out == CAP_VALUE && msr_rdata_out[7:0] == 8'h08)
        else $error("capability read wrong");
    cap_write_a: assert property (msr_req_in.wr && is_cap |=> msr_ack_out && msr_fault_out)
        else $error("capability write not faulted");
    bad_type_a: assert property (msr_req_in.wr && is_def && !type_ok(msr_req_in.data[7:0]) |=> msr_fault_out && $stable(def_ff))
        else $error("reserved type accepted");
    range_purge_a: assert property (msr_req_in.wr && (is_fix || is_var) && !wr_bad |=> purge_out.all)
        else $error("range write did not purge");
    pin_purge_a: assert property ($past(rstn_in) && $changed(purge_pin_n_in) |=> purge_out.all)
        else $error("pin edge did not purge");
    base_purge_a: assert property (cr_wr_in.valid && cr_wr_in.sel == RTM_CR_BASE |=> purge_out.nonpersist || purge_out.all)
        else $error("base write did not purge");
    paging_flip_a: assert property (s_paging_flip |=> purge_out.all)
        else $error("paging change did not purge");
    page_only_a: assert property (page_purge_in && !nxt_all |=> purge_out.page && purge_out.page_addr == $past(page_addr_in))
        else $error("single page purge lost");
    master_off_a: assert property (!def_ff[DEF_E_BIT] |=> mem_type_out == MT_UNCACHED)
        else $error("disabled map not uncached");
    feature_a: assert property (feature_bits_out[FEAT_RANGE_BIT])
        else $error("feature bit missing");

    // Flag flips, register answers and purge hygiene
    prot_flip_a: assert property (s_prot_flip |=> purge_out.all)
        else $error("protection change did not purge");
    ext_flip_a: assert property (s_ext_flip |=> purge_out.all)
        else $error("extension change did not purge");
    msr_ack_a: assert property (s_msr_req |=> msr_ack_out)
        else $error("register answer missing");
    ack_idle_a: assert property (s_msr_idle |=> !msr_ack_out && !msr_fault_out)
        else $error("answer without request");
    def_read_a: assert property (msr_req_in.rd && is_def |=> msr_rdata_out == $past(def_ff))
        else $error("default register read wrong");
    unmapped_read_a: assert property (msr_req_in.rd && !mapped |=> msr_fault_out && msr_rdata_out == '0)
        else $error("unmapped read not faulted");
    fix_type_a: assert property (msr_req_in.wr && is_fix && !bytes_ok(msr_req_in.data) |=> msr_fault_out)
        else $error("reserved fixed type accepted");
    var_rsvd_a: assert property (msr_req_in.wr && is_var && var_bad |=> msr_fault_out)
        else $error("reserved variable bits accepted");
    no_partial_a: assert property (purge_out.all |-> !purge_out.nonpersist && !purge_out.page)
        else $error("partial purge beside full purge");
    quiet_purge_a: assert property (s_no_cause |=> purge_out == '0)
        else $error("purge without cause");

    // Lookup type follows the group that owns the address
    fixed_win_a: assert property (s_fixed_on |=> mem_type_out == $past(fix_type))
        else $error("fixed range type lost");
    var_win_a: assert property (s_var_on |=> mem_type_out == $past(var_type))
        else $error("variable range type lost");
endmodule : rtm_core

`default_nettype wire

// ===== tb/rtm_pipe_model.sv
// Model of the execution pipeline that issues register, control and purge requests
`timescale 1ns/1ns
`default_nettype none
module rtm_pipe_model import rtm_pkg::*; (
    input wire logic clk_in,
    output rtm_msr_req_t msr_req_out,
    output rtm_cr_wr_t cr_wr_out,
    output logic page_purge_out,
    output logic [31:0] page_addr_out,
    output logic purge_pin_n_out
);
    // Idle state: no strobes, pin released
    initial begin
        msr_req_out = '0;
        cr_wr_out = '{valid: 1'b0, sel: RTM_CR_NONE, data: 32'h0000_0000};
        page_purge_out = 1'b0;
        page_addr_out = 32'h0000_0000;
        purge_pin_n_out = 1'b1;
    end

    // One-cycle strobe; released fields show inverted data so no stale value is trusted
    task automatic msr(input logic wr, input logic [15:0] addr, input logic [63:0] data);
        @(posedge clk_in);
        #1 msr_req_out = '{wr: wr, rd: !wr, addr: addr, data: data};
        @(posedge clk_in);
        #1 msr_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
    endtask : msr

    task automatic cr(input rtm_cr_sel_t sel, input logic [31:0] data);
        @(posedge clk_in);
        #1 cr_wr_out = '{valid: 1'b1, sel: sel, data: data};
        @(posedge clk_in);
        #1 cr_wr_out = '{valid: 1'b0, sel: RTM_CR_NONE, data: ~data};
    endtask : cr

    task automatic page(input logic [31:0] addr);
        @(posedge clk_in);
        #1 page_purge_out = 1'b1;
        page_addr_out = addr;
        @(posedge clk_in);
        #1 page_purge_out = 1'b0;
        page_addr_out = ~addr;
    endtask : page

    // Pin level is held, the design reacts to the change
    task automatic pin(input logic level);
        @(posedge clk_in);
        #1 purge_pin_n_out = level;
        @(posedge clk_in);
        #1;
    endtask : pin
endmodule : rtm_pipe_model
`default_nettype wire

// ===== tb/range_type_map_and_tlb_purge_tb.sv
// Self-checking testbench of the range type map and purge control
`timescale 1ns/1ns
`default_nettype none
module range_type_map_and_tlb_purge_tb import rtm_pkg::*; ();
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [35:0] lookup_addr_in = 36'h0_0000_0000;
    rtm_msr_req_t msr_req;
    rtm_cr_wr_t cr_wr;
    logic page_purge, purge_pin_n, msr_ack_out, msr_fault_out;
    logic [31:0] page_addr, feature_bits_out;
    logic [63:0] msr_rdata_out;
    rtm_purge_t purge_out;
    logic [7:0] mem_type_out;
    int n_mismatch = 0;
    int n_tests = 0;

    always #10 ref_clk_in = ~ref_clk_in;

    rtm_pipe_model pipe (.clk_in(ref_clk_in), .msr_req_out(msr_req), .cr_wr_out(cr_wr),
        .page_purge_out(page_purge), .page_addr_out(page_addr), .purge_pin_n_out(purge_pin_n));
    rtm_core #(.PHYS_W(36)) dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .msr_req_in(msr_req),
        .cr_wr_in(cr_wr), .page_purge_in(page_purge), .page_addr_in(page_addr),
        .purge_pin_n_in(purge_pin_n), .lookup_addr_in(lookup_addr_in), .msr_ack_out(msr_ack_out),
        .msr_fault_out(msr_fault_out), .msr_rdata_out(msr_rdata_out), .purge_out(purge_out),
        .feature_bits_out(feature_bits_out), .mem_type_out(mem_type_out));

    // Expected-value helpers
    function automatic logic type_legal(input logic [7:0] t);
        return t inside {MT_UNCACHED, MT_COMBINING, MT_THROUGH, MT_PROTECTED, MT_BACK};
    endfunction : type_legal
    function automatic logic [2:0] pv();
        return {purge_out.all, purge_out.nonpersist, purge_out.page};
    endfunction : pv

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    // A refused write stores nothing and purges nothing; an accepted one purges all
    task automatic wr(input logic [15:0] a, input logic [63:0] d, input logic f);
        pipe.msr(1'b1, a, d);
        chk({msr_ack_out, msr_fault_out}, {1'b1, f}, "write answer");
        chk(pv(), f ? 3'b000 : 3'b100, "write purge");
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [63:0] d, input logic f);
        pipe.msr(1'b0, a, d);
        chk({msr_ack_out, msr_fault_out}, {1'b1, f}, "read answer");
        chk(msr_rdata_out, d, "read data");
    endtask : rd
    task automatic cr(input rtm_cr_sel_t s, input logic [31:0] d, input logic [2:0] e);
        pipe.cr(s, d);
        chk(pv(), e, "control purge");
    endtask : cr
    task automatic look(input logic [35:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        #1 lookup_addr_in = a;
        @(posedge ref_clk_in);
        #1 chk(mem_type_out, e, "lookup type");
    endtask : look

    // Watchdog: the run is short, a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end

    initial begin
        logic [7:0] code;
        logic [31:0] pa;
        void'($urandom(32036));
        repeat (20) @(posedge ref_clk_in);
        #1 rstn_in = 1'b1;
        chk(feature_bits_out[12], 1'b1, "feature bit");
        chk(mem_type_out, MT_UNCACHED, "reset type");
        rd(ADDR_DEF, DEF_RESET, 1'b0);
        rd(ADDR_CAP, 64'h0000_0000_0000_0508, 1'b0);
        chk(msr_rdata_out[7:0], 8'h08, "range count");
        chk({msr_rdata_out[10], msr_rdata_out[8]}, 2'b11, "cap flags");
        wr(ADDR_CAP, 64'h0000_0000_0000_0000, 1'b1);
        rd(16'h0FFF, 64'h0000_0000_0000_0000, 1'b1);
        $display("test reset_and_capability done");
        // Every small code plus random reserved codes into the default type
        for (int t = 0; t < 14; t++) begin
            code = (t < 9) ? 8'(t) : 8'($urandom_range(255, 9));
            wr(ADDR_DEF, {56'h0, code}, !type_legal(code));
        end
        wr(ADDR_VAR0, 64'h0000_0000_0000_0003, 1'b1);
        $display("test type_codes done");
        wr(ADDR_VAR0 + 16'h0002, 64'h0000_0004_0000_0006, 1'b0);
        wr(ADDR_VAR0 + 16'h0003, 64'h0000_000F_F000_0800, 1'b0);
        wr(ADDR_DEF, 64'h0000_0000_0000_0804, 1'b0);
        for (int i = 0; i < 6; i++) begin
            look({8'h40, 28'($urandom)}, MT_BACK);
            look({8'h80, 28'($urandom)}, MT_THROUGH);
        end
        wr(ADDR_DEF, 64'h0000_0000_0000_0006, 1'b0);
        look({8'h40, 28'($urandom)}, MT_UNCACHED);
        wr(ADDR_DEF, 64'h0000_0000_0000_0106, 1'b1);
        wr(ADDR_VAR0 + 16'h0001, 64'h0000_0010_0000_0800, 1'b1);
        rd(ADDR_VAR0 + 16'h0002, 64'h0000_0004_0000_0006, 1'b0);
        $display("test variable_range done");
        // Fixed ranges win below 1 MiB only while their enable is set
        wr(ADDR_FIX0, 64'h0101_0101_0101_0105, 1'b0);
        wr(ADDR_FIX0 + 16'h0003, 64'h0000_0400_0000_0000, 1'b0);
        wr(ADDR_FIX0 + 16'h0001, 64'h0000_0000_0200_0000, 1'b1);
        wr(ADDR_DEF, 64'h0000_0000_0000_0C06, 1'b0);
        look(36'h0_0000_1234, MT_PROTECTED);
        look(36'h0_0007_0000, MT_COMBINING);
        look(36'h0_000C_5000, MT_THROUGH);
        wr(ADDR_DEF, 64'h0000_0000_0000_0806, 1'b0);
        look(36'h0_0000_1234, MT_BACK);
        $display("test fixed_range done");
        cr(RTM_CR_BASE, $urandom, 3'b010);
        cr(RTM_CR_PRIMARY, 32'h8000_0001, 3'b100);
        cr(RTM_CR_PRIMARY, 32'h8000_0003, 3'b000);
        cr(RTM_CR_PRIMARY, 32'h0000_0003, 3'b100);
        cr(RTM_CR_PRIMARY, 32'h0000_0002, 3'b100);
        cr(RTM_CR_EXT, 32'h0000_0010, 3'b100);
        cr(RTM_CR_EXT, 32'h0000_0030, 3'b100);
        cr(RTM_CR_EXT, 32'h0000_00B0, 3'b100);
        cr(RTM_CR_EXT, 32'h0000_00B1, 3'b000);
        cr(RTM_CR_NONE, 32'h0000_00FF, 3'b000);
        $display("test control_writes done");
        pa = $urandom;
        pipe.page(pa);
        chk({pv(), purge_out.page_addr}, {3'b001, pa}, "page purge");
        pipe.pin(1'b0);
        chk(pv(), 3'b100, "pin asserted");
        pipe.pin(1'b0);
        chk(pv(), 3'b000, "pin held");
        pipe.pin(1'b1);
        chk(pv(), 3'b100, "pin released");
        $display("test page_and_pin done");
        // A reset in mid-run drops the whole map back to uncached
        rstn_in = 1'b0;
        repeat (3) @(posedge ref_clk_in);
        #1 rstn_in = 1'b1;
        chk(mem_type_out, MT_UNCACHED, "type after reset");
        rd(ADDR_FIX0, 64'h0000_0000_0000_0000, 1'b0);
        rd(ADDR_DEF, DEF_RESET, 1'b0);
        $display("test mid_run_reset done");
        conclude();
    end
endmodule : range_type_map_and_tlb_purge_tb
`default_nettype wire
